// [hdl/nv_spi_memory.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Master waits power-up time before first select.
// - Set-latch sets, clear-latch clears write latch.
// - Latch clears at reset; master sets first.
// - Select rise after clear/status/array write clears latch.
// - Status write data never sets the latch bit.
// - Status bits: pin guard 7, guards 3:2, latch 1.
// - Bits 0,4,5,6 read zero, ignore writes.
// - Block-guard bits survive power cycles.
// - Guard codes protect none, 600h, 400h, all.
// - Pin blocks status write only when enabled.
// - Array write needs latch and unguarded address.
// - Status read returns one status byte.
// - Status write updates pin guard and guards.
// - Two address bytes, upper five bits ignored.
// - Write address increments, wraps 7FFh to 000h.
// - Each byte commits after eighth clock.
// - Guarded address stops increment, drops data.
// - Read drives data, ignores serial input.
// - Read continues sequentially, wraps, MSB first.
// - Select rise ends read, output released.
// - Sample rising, shift falling; mode from clock.
// - Unknown opcode ignored until next select fall.
// - Deselected: input ignored, output released.
module nv_spi_memory
    import nv_spi_pkg::*;
#(
    parameter int DEPTH = 2048
) (
    input wire logic clk_in,
    input wire logic rst_in,
    nv_spi_if.memory spi,
    output logic [7:0] status_out,
    output logic busy_out
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_OPCODE = 7'h02,
        ST_ADDR_HI = 7'h04,
        ST_ADDR_LO = 7'h08,
        ST_DATA = 7'h10,
        ST_STATUS = 7'h20,
        ST_IGNORE = 7'h40
    } mem_state_t;

    function automatic logic guarded(input logic [1:0] guard, input logic [10:0] addr);
        case (guard)
            2'b00: guarded = 1'b0;
            2'b01: guarded = addr >= QUARTER_BASE;
            2'b10: guarded = addr >= HALF_BASE;
            default: guarded = 1'b1;
        endcase
    endfunction

    logic [2:0] cs_sync, sck_sync, mosi_sync;
    logic [1:0] wp_sync;
    logic [7:0] mem [DEPTH];
    mem_state_t state;
    logic [7:0] opcode, shift_in, shift_out;
    logic [2:0] bit_cnt;
    logic [10:0] addr;
    logic latch, stop;
    // Not cleared by rst_in: stands in for the nonvolatile cells
    logic pin_guard = STATUS_RESET[PIN_GUARD_POS];
    logic [1:0] guard = STATUS_RESET[GUARD_HIGH_POS:GUARD_LOW_POS];
    logic miso, miso_oe;
    logic cs_fall, cs_rise, sck_rise, sck_fall, selected;
    logic [7:0] in_byte, status_byte;
    logic byte_done;

    // Two flops before use; third stage is the edge reference
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_sync <= 3'h7;
            sck_sync <= 3'h0;
            mosi_sync <= 3'h0;
            wp_sync <= 2'h3;
        end else begin
            cs_sync <= {cs_sync[1:0], spi.chip_select_n};
            sck_sync <= {sck_sync[1:0], spi.sck};
            mosi_sync <= {mosi_sync[1:0], spi.mosi};
            wp_sync <= {wp_sync[0], spi.write_guard_n};
        end
    end

    assign cs_fall = cs_sync[2] & ~cs_sync[1];
    assign cs_rise = ~cs_sync[2] & cs_sync[1];
    assign selected = ~cs_sync[1];
    // Mode 3 idle-high clock gives no spurious rise; edges alone suffice
    assign sck_rise = selected & ~sck_sync[2] & sck_sync[1];
    assign sck_fall = selected & sck_sync[2] & ~sck_sync[1];
    assign in_byte = {shift_in[6:0], mosi_sync[1]};
    assign byte_done = sck_rise && bit_cnt == BYTE_LAST_BIT;
    assign status_byte = {pin_guard, 3'h0, guard, latch, 1'b0};

    always_ff @(posedge clk_in) begin
        if (rst_in || cs_fall || cs_rise) begin
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= in_byte;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            opcode <= 8'h00;
            addr <= 11'h000;
            stop <= 1'b0;
        end else if (cs_rise) begin
            state <= ST_IDLE;
        end else if (cs_fall) begin
            state <= ST_OPCODE;
            stop <= 1'b0;
        end else if (byte_done) begin
            case (state)
                ST_OPCODE: begin
                    opcode <= in_byte;
                    case (in_byte)
                        ARRAY_READ_CMD, ARRAY_WRITE_CMD: state <= ST_ADDR_HI;
                        STATUS_READ_CMD, STATUS_WRITE_CMD: state <= ST_STATUS;
                        SET_LATCH_CMD, CLEAR_LATCH_CMD: state <= ST_IGNORE;
                        default: state <= ST_IGNORE;
                    endcase
                end
                ST_ADDR_HI: begin
                    addr[10:8] <= in_byte[2:0];
                    state <= ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    addr[7:0] <= in_byte;
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    if (opcode == ARRAY_READ_CMD) begin
                        addr <= addr + 11'h001;
                    end else if (!stop && !guarded(guard, addr)) begin
                        addr <= addr + 11'h001;
                    end else begin
                        stop <= 1'b1;
                    end
                end
                ST_STATUS: state <= ST_IGNORE;
                default: state <= state;
            endcase
        end
    end

    // Array commit on eighth clock, no page buffer
    always_ff @(posedge clk_in) begin
        if (byte_done && state == ST_DATA && opcode == ARRAY_WRITE_CMD && latch && !stop
            && !guarded(guard, addr)) begin
            mem[addr] <= in_byte;
        end
    end

    // Latch is volatile; guard bits keep value over rst_in as a stand-in for nonvolatile cells
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            latch <= 1'b0;
        end else if (cs_rise && state != ST_OPCODE && (opcode == CLEAR_LATCH_CMD
                     || opcode == STATUS_WRITE_CMD || opcode == ARRAY_WRITE_CMD)) begin
            latch <= 1'b0;
        end else if (byte_done && state == ST_OPCODE && in_byte == SET_LATCH_CMD) begin
            latch <= 1'b1;
        end else if (byte_done && state == ST_OPCODE && in_byte == CLEAR_LATCH_CMD) begin
            latch <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (byte_done && state == ST_STATUS && opcode == STATUS_WRITE_CMD && latch
            && !(pin_guard && !wp_sync[1])) begin
            pin_guard <= in_byte[PIN_GUARD_POS];
            guard <= {in_byte[GUARD_HIGH_POS], in_byte[GUARD_LOW_POS]};
        end
    end

    // A partial opcode never leaves ST_OPCODE, so select rise skips the latch clear

    always_ff @(posedge clk_in) begin
        if (rst_in || cs_rise || cs_fall) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
            shift_out <= 8'h00;
        end else if (byte_done && state == ST_OPCODE && in_byte == STATUS_READ_CMD) begin
            shift_out <= status_byte;
        end else if (byte_done && state == ST_ADDR_LO && opcode == ARRAY_READ_CMD) begin
            shift_out <= mem[{addr[10:8], in_byte}];
        end else if (byte_done && state == ST_DATA && opcode == ARRAY_READ_CMD) begin
            shift_out <= mem[addr + 11'h001];
        end else if (byte_done && state == ST_STATUS) begin
            miso_oe <= 1'b0;
        end else if (sck_fall && (state == ST_DATA && opcode == ARRAY_READ_CMD
                     || state == ST_STATUS && opcode == STATUS_READ_CMD)) begin
            miso <= shift_out[7];
            miso_oe <= 1'b1;
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    assign spi.miso = miso;
    assign spi.miso_oe = miso_oe;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out <= STATUS_RESET;
            busy_out <= 1'b0;
        end else begin
            status_out <= status_byte;
            busy_out <= selected;
        end
    end
endmodule
`default_nettype wire

// [hdl/nv_spi_pkg.sv]
package nv_spi_pkg;
    localparam logic [7:0] SET_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
    localparam int ADDR_BITS = 11;
    localparam int PIN_GUARD_POS = 7;
    localparam int GUARD_HIGH_POS = 3;
    localparam int GUARD_LOW_POS = 2;
    localparam int LATCH_POS = 1;
    localparam logic [10:0] QUARTER_BASE = 11'h600;
    localparam logic [10:0] HALF_BASE = 11'h400;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 100;
    localparam int POWERUP_WAIT_NS = 1000;
    localparam int POWERUP_WAIT_CYCLES = (POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_SCK_NS = 400;
    localparam int HALF_SCK_CYCLES = HALF_SCK_NS / CLK_PERIOD_NS;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
endpackage

// [hdl/nv_spi_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface nv_spi_if;
    logic chip_select_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic write_guard_n;
    modport memory (
        input chip_select_n, sck, mosi, write_guard_n,
        output miso, miso_oe
    );
    modport master (
        output chip_select_n, sck, mosi, write_guard_n,
        input miso, miso_oe
    );
endinterface
`default_nettype wire

// [hdl/nv_spi_master.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_spi_master
    import nv_spi_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [7:0] opcode_in,
    input wire logic [10:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] count_in,
    input wire logic guard_pin_in,
    nv_spi_if.master spi,
    output logic ready_out,
    output logic [7:0] rdata_out,
    output logic rvalid_out
);
    typedef enum logic [3:0] {
        M_WAIT = 4'h1,
        M_IDLE = 4'h2,
        M_SHIFT = 4'h4,
        M_END = 4'h8
    } master_state_t;

    master_state_t state;
    logic [7:0] tx, rx, bytes_left;
    logic [2:0] bit_cnt;
    logic [7:0] div;
    logic [1:0] phase;
    logic [1:0] miso_sync;
    logic cs_n, sck, first;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            miso_sync <= 2'h0;
        end else begin
            miso_sync <= {miso_sync[0], spi.miso};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= M_WAIT;
            div <= 8'h00;
            cs_n <= 1'b1;
            sck <= 1'b0;
            tx <= 8'h00;
            rx <= 8'h00;
            bit_cnt <= 3'h0;
            bytes_left <= 8'h00;
            phase <= 2'h0;
            ready_out <= 1'b0;
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
            first <= 1'b0;
        end else begin
            rvalid_out <= 1'b0;
            case (state)
                M_WAIT: begin
                    div <= div + 8'h01;
                    if (div == 8'(POWERUP_WAIT_CYCLES)) begin
                        state <= M_IDLE;
                        ready_out <= 1'b1;
                    end
                end
                M_IDLE: begin
                    if (start_in) begin
                        ready_out <= 1'b0;
                        cs_n <= 1'b0;
                        tx <= opcode_in;
                        phase <= 2'h0;
                        first <= 1'b1;
                        bytes_left <= (opcode_in == ARRAY_READ_CMD || opcode_in == ARRAY_WRITE_CMD)
                            ? count_in + 8'h02 : count_in;
                        bit_cnt <= 3'h0;
                        div <= 8'h00;
                        state <= M_SHIFT;
                    end
                end
                M_SHIFT: begin
                    div <= div + 8'h01;
                    if (div == 8'(HALF_SCK_CYCLES - 1)) begin
                        div <= 8'h00;
                        sck <= ~sck;
                        // Sample late in the high phase: both synchronisers together outlast half a clock
                        if (sck) begin
                            rx <= {rx[6:0], miso_sync[1]};
                        end
                        if (sck && bit_cnt == BYTE_LAST_BIT) begin
                            bit_cnt <= 3'h0;
                            rdata_out <= {rx[6:0], miso_sync[1]};
                            rvalid_out <= !first;
                            first <= 1'b0;
                            phase <= (phase == 2'h2) ? phase : phase + 2'h1;
                            if (bytes_left == 8'h00) begin
                                state <= M_END;
                            end else begin
                                bytes_left <= bytes_left - 8'h01;
                                tx <= (phase == 2'h0 && bytes_left > count_in) ? {5'h00, addr_in[10:8]}
                                    : (phase == 2'h1 && bytes_left > count_in) ? addr_in[7:0] : wdata_in;
                            end
                        end else if (sck) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    div <= div + 8'h01;
                    if (div == 8'(HALF_SCK_CYCLES - 1)) begin
                        cs_n <= 1'b1;
                        ready_out <= 1'b1;
                        state <= M_IDLE;
                    end
                end
            endcase
        end
    end

    assign spi.chip_select_n = cs_n;
    assign spi.sck = sck;
    assign spi.mosi = tx[7];
    assign spi.write_guard_n = guard_pin_in;
endmodule
`default_nettype wire

// [verif/nv_spi_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_spi_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic [7:0] status_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_release_bound: assert property ($rose(chip_select_n) |-> ##[0:6] !miso_oe) else $error("out not released");
    a_idle_quiet: assert property (chip_select_n [*8] |-> !miso_oe) else $error("out driven while idle");
    a_oe_needs_sel: assert property ($rose(miso_oe) |-> !chip_select_n) else $error("out driven unselected");
    a_fixed_zero: assert property (status_out[6:4] == 3'h0 && !status_out[0]) else $error("fixed bit set");
    a_latch_set_sel: assert property ($rose(status_out[1]) |-> $past(busy_out)) else $error("latch set idle");
    a_guard_latch: assert property ($changed(status_out[7:2]) |-> $past(status_out[1])) else $error("no latch");
    a_mode_zero: assert property ($fell(chip_select_n) |-> !sck) else $error("clock high at select");
    a_mosi_steady: assert property ($rose(sck) |-> $stable(mosi)) else $error("input moved at rise");
    a_sck_framed: assert property ($changed(sck) |-> !chip_select_n) else $error("clock outside frame");
    a_busy_on_sel: assert property ($fell(chip_select_n) |-> ##[1:4] busy_out) else $error("busy missing");
    c_latch_set: cover property ($rose(status_out[1]));
    c_guard_change: cover property ($changed(status_out[3:2]));
    c_read_drive: cover property ($rose(miso_oe));
endmodule
`default_nettype wire

// [verif/tb_nv_spi_memory.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_nv_spi_memory
    import nv_spi_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic [7:0] opcode_in = 8'h00;
    logic [10:0] addr_in = 11'h000;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] count_in = 8'h00;
    logic guard_pin_in = 1'b1;
    logic ready_out, rvalid_out, busy_out;
    logic [7:0] rdata_out, status_out;
    logic [7:0] rx[$];
    logic [7:0] m_lo, m_hi, d;
    logic stop;
    int num_errors = 0;
    int num_checks = 0;
    nv_spi_if bus();
    nv_spi_memory nv_spi_memory_inst (.clk_in(clk_in), .rst_in(rst_in), .spi(bus),
        .status_out(status_out), .busy_out(busy_out));
    nv_spi_master nv_spi_master_inst (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
        .opcode_in(opcode_in), .addr_in(addr_in), .wdata_in(wdata_in), .count_in(count_in),
        .guard_pin_in(guard_pin_in), .spi(bus), .ready_out(ready_out), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out));
    nv_spi_chk nv_spi_chk_inst (.clk_in(clk_in), .rst_in(rst_in), .chip_select_n(bus.chip_select_n),
        .sck(bus.sck), .mosi(bus.mosi), .miso_oe(bus.miso_oe), .status_out(status_out), .busy_out(busy_out));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (rvalid_out === 1'b1) begin
            rx.push_back(rdata_out);
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Ready is sampled before the edge's own updates land
    task automatic cmd(input logic [7:0] op, input logic [10:0] a, input logic [7:0] wd, input logic [7:0] n);
        int i;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (ready_out !== 1'b1 && i < 5000);
        if (ready_out !== 1'b1) begin
            num_errors++;
        end
        rx.delete();
        start_in <= 1'b1;
        opcode_in <= op;
        addr_in <= a;
        wdata_in <= wd;
        count_in <= n;
        @(posedge clk_in);
        start_in <= 1'b0;
        i = 0;
        do begin
            @(posedge clk_in);
            i++;
        end while (ready_out !== 1'b1 && i < 5000);
        if (ready_out !== 1'b1) begin
            num_errors++;
        end
    endtask
    task automatic status_is(input logic [7:0] exp);
        cmd(STATUS_READ_CMD, 11'h000, 8'h00, 8'h01);
        check("status byte", rx[rx.size() - 1], exp);
        check("status_out", status_out, exp);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        status_is(8'h00);
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        status_is(8'h02);
        cmd(CLEAR_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        status_is(8'h00);
        $display("latch test done");
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(ARRAY_WRITE_CMD, 11'h010, 8'ha5, 8'h01);
        status_is(8'h00);
        cmd(ARRAY_WRITE_CMD, 11'h010, 8'h3c, 8'h01);
        cmd(ARRAY_READ_CMD, 11'h010, 8'h00, 8'h01);
        check("array byte", rx[rx.size() - 1], 8'ha5);
        $display("array latch test done");
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(STATUS_WRITE_CMD, 11'h000, 8'hff, 8'h01);
        status_is(8'h8c);
        guard_pin_in <= 1'b0;
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(STATUS_WRITE_CMD, 11'h000, 8'h00, 8'h01);
        status_is(8'h8c);
        guard_pin_in <= 1'b1;
        cmd(8'hff, 11'h000, 8'h00, 8'h01);
        status_is(8'h8c);
        $display("status write test done");
        for (int g = 0; g < 4; g++) begin
            cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
            cmd(STATUS_WRITE_CMD, 11'h000, {4'h0, g[1:0], 2'b00}, 8'h01);
            status_is({4'h0, g[1:0], 2'b00});
            d = 8'h11 + 8'(g);
            cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
            cmd(ARRAY_WRITE_CMD, 11'h5ff, d, 8'h02);
            // Once a guarded address is hit, later bytes are dropped too
            stop = (g >= 2);
            if (!stop) m_lo = d;
            stop = stop || (g >= 1);
            if (!stop) m_hi = d;
            cmd(ARRAY_READ_CMD, 11'h5ff, 8'h00, 8'h02);
            check("below boundary", rx[rx.size() - 2], m_lo);
            check("at boundary", rx[rx.size() - 1], m_hi);
        end
        $display("guard range test done");
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(STATUS_WRITE_CMD, 11'h000, 8'h00, 8'h01);
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(ARRAY_WRITE_CMD, 11'h001, 8'h11, 8'h01);
        cmd(SET_LATCH_CMD, 11'h000, 8'h00, 8'h00);
        cmd(ARRAY_WRITE_CMD, 11'h7ff, 8'h77, 8'h02);
        cmd(ARRAY_READ_CMD, 11'h000, 8'h00, 8'h01);
        check("wrapped write", rx[rx.size() - 1], 8'h77);
        cmd(ARRAY_READ_CMD, 11'h7ff, 8'h00, 8'h03);
        check("wrapped read", rx[rx.size() - 2], 8'h77);
        check("read after wrap", rx[rx.size() - 1], 8'h11);
        $display("wrap test done");
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
